// *** fws_map.vh ***
// register offsets, field positions, reset values and timing counts
// of the flash write sequencer; included by its design files only
`ifndef FWS_MAP_VH
`define FWS_MAP_VH

// register indices on the 4-bit word address of the register port
`define FWS_A_CTRL0L  4'h0
`define FWS_A_CTRL0H  4'h1
`define FWS_A_SSEL_L  4'h2
`define FWS_A_SSEL_H  4'h3
`define FWS_A_ADDR_L  4'h4
`define FWS_A_ADDR_H  4'h5
`define FWS_A_D0_L    4'h6
`define FWS_A_D0_H    4'h7
`define FWS_A_D1_L    4'h8
`define FWS_A_D1_H    4'h9
`define FWS_A_ERR     4'hA
`define FWS_A_UNLOCK  4'hB
`define FWS_A_NVWP    4'hC
`define FWS_A_VOLWP   4'hD
`define FWS_A_NVAP    4'hE
`define FWS_A_NVDIS   4'hF

// ctrl0_high fields
`define FWS_B_START   15
`define FWS_B_SUSPEND_BIT    14
`define FWS_B_WPG     13
`define FWS_B_DWORD_PROG_SELECT    12
`define FWS_B_SER     11
`define FWS_B_SPR     8
// select code {word_prog, dword_prog, erase, set_protect}
`define FWS_OP_WPG    4'h8
`define FWS_OP_DWORD_PROG_SELECT   4'h4
`define FWS_OP_SER    4'h2
`define FWS_OP_SPR    4'h1

`define FWS_B_ADDR2   2
`define FWS_B_RESUME_ERROR_FLAG   0
`define FWS_B_TEMP_ACCESS_UNLOCK    0
`define FWS_B_ACCESS_PROTECT_BIT    0

// set-protection targets
`define FWS_PA_HIGH   16'h0008
`define FWS_PA_WP     16'hDFB4
`define FWS_PA_AP     16'hDFB8
`define FWS_PA_DIS    16'hDFBC

`define FWS_NV_RESET  16'hFFFF
`define FWS_VOL_RESET 16'h0000

// operation times, all at a 10 ns clock
`define FWS_CLK_NS    10
`define FWS_WPROG_NS  20000
`define FWS_DPROG_NS  40000
`define FWS_SPR_NS    40000
`define FWS_ERASE_NS  1000000
`define FWS_WPROG_CYC ((`FWS_WPROG_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_DPROG_CYC ((`FWS_DPROG_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SPR_CYC   ((`FWS_SPR_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_ERASE_CYC ((`FWS_ERASE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

`endif

// *** fws_op_timer.v ***
// pausable down-counter standing in for the flash array busy time
// assumes one clock; start, abort and pause are synchronous levels/pulses
`timescale 1ns/1ps
`default_nettype none
module fws_op_timer #(
  parameter CW = 20
) (
  input  wire          i_ref_clk,
  input  wire          i_resetn,
  input  wire          i_start,
  input  wire          i_abort,
  input  wire          i_pause,
  input  wire [CW-1:0] i_len,
  output wire          o_busy,
  output reg           o_done
);
  reg [CW-1:0] cnt_reg;

  assign o_busy = (cnt_reg != {CW{1'b0}});

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= {CW{1'b0}};
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        cnt_reg <= {CW{1'b0}};
      end else if (i_start) begin
        cnt_reg <= i_len;
      end else if (o_busy && !i_pause) begin
        cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
        if (cnt_reg == {{(CW-1){1'b0}}, 1'b1})
          o_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** fws_sequencer.v ***
// flash write sequencer: control registers, operation select and
// start, suspend/resume, nested program in erase suspend, protection
// assumes synchronous inputs and a single-cycle register port
//
// Summary of operation
// - set-protection writing ones sets volatile write-unprotect bits
// - reset or set-protection writing zeros restores sector write protection (reset here also sets nvwp_reg to 0xFFFF, so no sector stays protected)
// - unprotect sets volatile bits only; non-volatile zeros stay zero
// - unlock bit accepts a one only from flash instruction fetches
// - reset or writing zero to unlock bit restores access protection (reset here also sets nvap_reg to 0xFFFF, so access is unprotected)
// - all control register writes are 16-bit words
// - double-word program ignores address bit two, even-word aligned
// - suspend bit suspends running program or erase
// - sector-select registers read zero once erase completed
// - resume with changed select bits aborts and flags resume error
// - program inside erase suspend cannot be suspended
// - erase resumes on erase-select then start bit
// - during nested program erase-select and suspend read zero
// - double-word program: select, address, four data halves, start
// - sector write protection set at address 0x0008/0xDFB4
// - access protection set at 0xDFB8 with data 0xFFFC
// - access protected only while access bit and unlock bit zero
// - clearing select bit before start cancels the operation
// - operation launches only on write of the start bit
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fws_map.vh"
module fws_sequencer #(
  parameter CW        = 20,
  parameter WPROG_CYC = `FWS_WPROG_CYC,
  parameter DPROG_CYC = `FWS_DPROG_CYC,
  parameter SPR_CYC   = `FWS_SPR_CYC,
  parameter ERASE_CYC = `FWS_ERASE_CYC
) (
  input  wire        i_ref_clk,
  input  wire        i_resetn,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_fetch_from_flash,
  output reg  [15:0] o_rdata,
  output wire        o_busy,
  output wire        o_suspended,
  output wire        o_access_protected,
  output wire [15:0] o_sector_protected,
  output reg  [31:0] o_array_addr,
  output reg  [63:0] o_array_data
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_SUSPEND_BIT = 3'b100;

  localparam [CW-1:0] LEN_WPROG = WPROG_CYC[CW-1:0];
  localparam [CW-1:0] LEN_DPROG = DPROG_CYC[CW-1:0];
  localparam [CW-1:0] LEN_SPR   = SPR_CYC[CW-1:0];
  localparam [CW-1:0] LEN_ERASE = ERASE_CYC[CW-1:0];

  reg [2:0]  state_reg;
  reg [3:0]  sel_reg;
  reg        start_reg;
  reg        suspend_bit_reg;
  reg [3:0]  op_reg;
  reg [3:0]  prog_op_reg;
  reg        nested_reg;
  reg [15:0] ssel_l_reg;
  reg [15:0] ssel_h_reg;
  reg [15:0] addr_l_reg;
  reg [15:0] addr_h_reg;
  reg [15:0] d0_l_reg;
  reg [15:0] d0_h_reg;
  reg [15:0] d1_l_reg;
  reg [15:0] d1_h_reg;
  reg        resume_error_flag_reg;
  reg        temp_access_unlock_reg;
  reg [15:0] nvwp_reg;
  reg [15:0] volwp_reg;
  reg [15:0] nvap_reg;
  reg [15:0] nvdis_reg;

  // decode of a write to ctrl0_high
  wire [3:0] sel_w   = {i_wdata[`FWS_B_WPG], i_wdata[`FWS_B_DWORD_PROG_SELECT],
                        i_wdata[`FWS_B_SER], i_wdata[`FWS_B_SPR]};
  wire       start_w = i_wdata[`FWS_B_START];
  wire       suspend_bit_w  = i_wdata[`FWS_B_SUSPEND_BIT];
  wire       sel_one = (sel_w == `FWS_OP_WPG) || (sel_w == `FWS_OP_DWORD_PROG_SELECT) ||
                       (sel_w == `FWS_OP_SER) || (sel_w == `FWS_OP_SPR);
  wire       sel_prog = (sel_w == `FWS_OP_WPG) || (sel_w == `FWS_OP_DWORD_PROG_SELECT);

  wire acc_prot = ~nvap_reg[`FWS_B_ACCESS_PROTECT_BIT] & ~temp_access_unlock_reg;
  // flash registers other than the unlock bit cannot be written while access protected
  wire wr_ok   = i_wr & ~acc_prot;
  wire wr_ctrl = wr_ok && (i_addr == `FWS_A_CTRL0H);
  // latched operands stay frozen while the array works
  wire wr_data = wr_ok && (state_reg != ST_RUN);

  wire [3:0] run_op = nested_reg ? prog_op_reg : op_reg;

  // program timer also serves set-protection; erase has its own so
  // a nested program can run while the erase count stays paused
  reg          p_start;
  reg          e_start;
  reg          abort;
  reg [CW-1:0] p_len;
  wire         p_done;
  wire         e_done;
  wire         p_busy;
  wire         e_busy;
  wire         p_pause = (state_reg == ST_SUSPEND_BIT);
  wire         e_pause = (state_reg != ST_RUN) | nested_reg;

  fws_op_timer #(.CW(CW)) u_prog_timer (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_start   (p_start),
    .i_abort   (abort),
    .i_pause   (p_pause),
    .i_len     (p_len),
    .o_busy    (p_busy),
    .o_done    (p_done)
  );

  fws_op_timer #(.CW(CW)) u_erase_timer (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_start   (e_start),
    .i_abort   (abort),
    .i_pause   (e_pause),
    .i_len     (LEN_ERASE),
    .o_busy    (e_busy),
    .o_done    (e_done)
  );

  // launch, resume and abort decisions for a ctrl0_high write
  reg launch;
  reg resume;
  reg nest;
  always @* begin
    launch = 1'b0;
    resume = 1'b0;
    nest   = 1'b0;
    abort  = 1'b0;
    if (wr_ctrl && start_w && !suspend_bit_w) begin
      case (state_reg)
        ST_IDLE: launch = sel_one;
        ST_SUSPEND_BIT: begin
          if (sel_w == op_reg)
            resume = 1'b1;
          else if (op_reg == `FWS_OP_SER && sel_prog)
            nest = 1'b1;
          else
            abort = 1'b1;
        end
        default: launch = 1'b0;
      endcase
    end
    p_start = (launch && sel_w != `FWS_OP_SER) || nest;
    e_start = launch && (sel_w == `FWS_OP_SER);
    case (sel_w)
      `FWS_OP_WPG:  p_len = LEN_WPROG;
      `FWS_OP_DWORD_PROG_SELECT: p_len = LEN_DPROG;
      default:      p_len = LEN_SPR;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg   <= ST_IDLE;
      sel_reg     <= 4'h0;
      start_reg   <= 1'b0;
      suspend_bit_reg    <= 1'b0;
      op_reg      <= 4'h0;
      prog_op_reg <= 4'h0;
      nested_reg  <= 1'b0;
      ssel_l_reg  <= 16'h0000;
      ssel_h_reg  <= 16'h0000;
      addr_l_reg  <= 16'h0000;
      addr_h_reg  <= 16'h0000;
      d0_l_reg    <= 16'h0000;
      d0_h_reg    <= 16'h0000;
      d1_l_reg    <= 16'h0000;
      d1_h_reg    <= 16'h0000;
      resume_error_flag_reg   <= 1'b0;
      temp_access_unlock_reg    <= 1'b0;
      nvwp_reg    <= `FWS_NV_RESET;
      volwp_reg   <= `FWS_VOL_RESET;
      nvap_reg    <= `FWS_NV_RESET;
      nvdis_reg   <= `FWS_NV_RESET;
      o_array_addr <= 32'h0000_0000;
      o_array_data <= 64'h0000_0000_0000_0000;
    end else begin
      // operand registers
      if (wr_data) begin
        case (i_addr)
          `FWS_A_SSEL_L: ssel_l_reg <= i_wdata;
          `FWS_A_SSEL_H: ssel_h_reg <= i_wdata;
          `FWS_A_ADDR_L: addr_l_reg <= i_wdata;
          `FWS_A_ADDR_H: addr_h_reg <= i_wdata;
          `FWS_A_D0_L:   d0_l_reg   <= i_wdata;
          `FWS_A_D0_H:   d0_h_reg   <= i_wdata;
          `FWS_A_D1_L:   d1_l_reg   <= i_wdata;
          `FWS_A_D1_H:   d1_h_reg   <= i_wdata;
          default:       d1_h_reg   <= d1_h_reg;
        endcase
      end
      // writing zero clears the resume error; a new error wins below
      if (wr_ok && i_addr == `FWS_A_ERR && !i_wdata[`FWS_B_RESUME_ERROR_FLAG])
        resume_error_flag_reg <= 1'b0;
      // unlock bit: clearing always allowed, setting only from flash
      if (i_wr && i_addr == `FWS_A_UNLOCK) begin
        if (!i_wdata[`FWS_B_TEMP_ACCESS_UNLOCK])
          temp_access_unlock_reg <= 1'b0;
        else if (i_fetch_from_flash)
          temp_access_unlock_reg <= 1'b1;
      end

      if (wr_ctrl) begin
        case (state_reg)
          ST_IDLE: begin
            sel_reg  <= sel_w;
            suspend_bit_reg <= suspend_bit_w;
          end
          ST_RUN: begin
            // nested program and set-protection are not suspendable
            if (suspend_bit_w && !nested_reg && op_reg != `FWS_OP_SPR) begin
              suspend_bit_reg  <= 1'b1;
              state_reg <= ST_SUSPEND_BIT;
            end
          end
          ST_SUSPEND_BIT: begin
            sel_reg  <= sel_w;
            suspend_bit_reg <= suspend_bit_w;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end

      if (launch || nest) begin
        start_reg <= 1'b1;
        state_reg <= ST_RUN;
        o_array_addr <= {addr_h_reg, addr_l_reg};
        if (sel_w == `FWS_OP_DWORD_PROG_SELECT)
          o_array_addr[`FWS_B_ADDR2] <= 1'b0;
        o_array_data <= {d1_h_reg, d1_l_reg, d0_h_reg, d0_l_reg};
      end
      if (launch)
        op_reg <= sel_w;
      if (nest) begin
        nested_reg  <= 1'b1;
        prog_op_reg <= sel_w;
      end
      if (resume) begin
        start_reg <= 1'b1;
        state_reg <= ST_RUN;
      end
      if (abort) begin
        resume_error_flag_reg <= 1'b1;
        state_reg <= ST_IDLE;
        start_reg <= 1'b0;
        sel_reg   <= 4'h0;
        op_reg    <= 4'h0;
      end

      // completion of the program timer
      if (p_done) begin
        start_reg <= 1'b0;
        sel_reg   <= 4'h0;
        if (nested_reg) begin
          // erase still suspended, waits for erase-select and start
          nested_reg <= 1'b0;
          state_reg  <= ST_SUSPEND_BIT;
        end else begin
          state_reg <= ST_IDLE;
          op_reg    <= 4'h0;
        end
        if (run_op == `FWS_OP_SPR && addr_h_reg == `FWS_PA_HIGH) begin
          case (addr_l_reg)
            `FWS_PA_WP: begin
              volwp_reg <= d0_l_reg;
              nvwp_reg  <= nvwp_reg & d0_l_reg;
            end
            `FWS_PA_AP:  nvap_reg  <= nvap_reg & d0_l_reg;
            `FWS_PA_DIS: nvdis_reg <= nvdis_reg & d0_l_reg;
            default:     nvdis_reg <= nvdis_reg;
          endcase
        end
      end
      if (e_done) begin
        start_reg  <= 1'b0;
        sel_reg    <= 4'h0;
        op_reg     <= 4'h0;
        state_reg  <= ST_IDLE;
        ssel_l_reg <= 16'h0000;
        ssel_h_reg <= 16'h0000;
      end
    end
  end

  // read data in the cycle after the strobe; bits of the selection
  // that are not in force read back as zero
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `FWS_A_CTRL0H: begin
          o_rdata <= 16'h0000;
          o_rdata[`FWS_B_START] <= start_reg;
          o_rdata[`FWS_B_SUSPEND_BIT]  <= suspend_bit_reg & ~nested_reg;
          o_rdata[`FWS_B_WPG]   <= sel_reg[3];
          o_rdata[`FWS_B_DWORD_PROG_SELECT]  <= sel_reg[2];
          o_rdata[`FWS_B_SER]   <= sel_reg[1] & ~nested_reg;
          o_rdata[`FWS_B_SPR]   <= sel_reg[0];
        end
        `FWS_A_SSEL_L: o_rdata <= ssel_l_reg;
        `FWS_A_SSEL_H: o_rdata <= ssel_h_reg;
        `FWS_A_ADDR_L: o_rdata <= addr_l_reg;
        `FWS_A_ADDR_H: o_rdata <= addr_h_reg;
        `FWS_A_D0_L:   o_rdata <= d0_l_reg;
        `FWS_A_D0_H:   o_rdata <= d0_h_reg;
        `FWS_A_D1_L:   o_rdata <= d1_l_reg;
        `FWS_A_D1_H:   o_rdata <= d1_h_reg;
        `FWS_A_ERR:    o_rdata <= {15'h0000, resume_error_flag_reg};
        `FWS_A_UNLOCK: o_rdata <= {15'h0000, temp_access_unlock_reg};
        `FWS_A_NVWP:   o_rdata <= nvwp_reg;
        `FWS_A_VOLWP:  o_rdata <= volwp_reg;
        `FWS_A_NVAP:   o_rdata <= nvap_reg;
        `FWS_A_NVDIS:  o_rdata <= nvdis_reg;
        default:       o_rdata <= 16'h0000;
      endcase
    end
  end

  assign o_busy             = (state_reg == ST_RUN);
  assign o_suspended        = (state_reg == ST_SUSPEND_BIT);
  assign o_access_protected = acc_prot;
  // a sector is write protected when neither copy holds a one
  assign o_sector_protected = ~(nvwp_reg | volwp_reg);
endmodule
`default_nettype wire

// *** fws_seq_properties.sv ***
// port-level checker of the flash write sequencer
// assumes one clock and the shortened operation counts of the bench
`timescale 1ns/1ps
`default_nettype none
module fws_seq_properties #(
  parameter int ERASE_CYC = 20
) (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_fetch_from_flash,
  input wire logic [15:0] o_rdata,
  input wire logic        o_busy,
  input wire logic        o_suspended,
  input wire logic        o_access_protected,
  input wire logic [15:0] o_sector_protected,
  input wire logic [31:0] o_array_addr,
  input wire logic [63:0] o_array_data
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic [31:0] busy_cnt;
  wire         unl_wr = i_wr && i_addr == 4'hB;
  // run length bound; a suspend also ends a run
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      busy_cnt <= '0;
    else
      busy_cnt <= o_busy ? busy_cnt + 32'd1 : '0;
  end
  AST_RD_HOLD: assert property (!$past(i_rd) |-> $stable(o_rdata))
    else $error("read data moved without a read");
  AST_START: assert property ($rose(o_busy) |->
    $past(i_wr && i_addr == 4'h1 && i_wdata[15]))
    else $error("run began without a start write");
  AST_LATCH: assert property (o_busy && $past(o_busy) |->
    $stable(o_array_addr) && $stable(o_array_data))
    else $error("latched address or data moved while running");
  AST_BUSY_LEN: assert property (busy_cnt <= ERASE_CYC + 2)
    else $error("operation never completed");
  AST_UNL_IGN: assert property (unl_wr && i_wdata[0] &&
    !i_fetch_from_flash && o_access_protected |=> o_access_protected)
    else $error("unlock from outside flash was taken");
  AST_UNL_SET: assert property (unl_wr && i_wdata[0] &&
    i_fetch_from_flash |=> !o_access_protected)
    else $error("unlock from flash was refused");
  AST_AP_FALL: assert property ($fell(o_access_protected) |->
    $past(unl_wr && i_wdata[0] && i_fetch_from_flash))
    else $error("access protection dropped without unlock");
  AST_AP_RISE: assert property ($rose(o_access_protected) |->
    $past(o_busy) || $past(unl_wr))
    else $error("access protection rose without cause");
  AST_WP_CHG: assert property ($changed(o_sector_protected) |->
    $past(o_busy))
    else $error("write protection moved outside an operation");
  AST_SUSPEND_BIT: assert property ($rose(o_suspended) |-> $past(o_busy))
    else $error("suspend entered while idle");
  cover property ($rose(o_suspended));
endmodule
bind fws_sequencer fws_seq_properties #(.ERASE_CYC(ERASE_CYC)) i_props (
  .i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_fetch_from_flash, .o_rdata, .o_busy, .o_suspended,
  .o_access_protected, .o_sector_protected, .o_array_addr,
  .o_array_data);
`default_nettype wire

// *** fws_cpu_model.sv ***
// cpu-side register master of the flash write sequencer
// assumes tasks are called from one process of the bench
`timescale 1ns/1ps
`default_nettype none
module fws_cpu_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rdata,
  output var  logic [3:0]  o_addr,
  output var  logic [15:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic        o_fetch_from_flash
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_fetch_from_flash = 1'b0;
  end
  // whole 16-bit words through a register index only
  task automatic wr(input logic [3:0] a, input logic [15:0] v,
                    input logic ff);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= v;
    o_fetch_from_flash <= ff;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    // code runs from ram between accesses
    o_fetch_from_flash <= 1'b0;
    o_wdata <= ~v;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    #1;
    v = i_rdata;
  endtask
endmodule
`default_nettype wire

// *** fws_sequencer_tb.sv ***
// self-checking bench of the flash write sequencer
// assumes shortened operation counts so a run stays brief
`timescale 1ns/1ps
`default_nettype none
`define FWS_CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end
module fws_sequencer_tb;
  logic        i_ref_clk;
  logic        i_resetn;
  wire  [3:0]  addr;
  wire  [15:0] wdata;
  wire         wr_s, rd_s, ffl, busy, suspend_bit, aprot;
  wire  [15:0] rdata, sprot;
  wire  [31:0] aaddr;
  wire  [63:0] adata;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [15:0] d;
  fws_sequencer #(.WPROG_CYC(5), .DPROG_CYC(7), .SPR_CYC(6),
    .ERASE_CYC(20)) i_dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .i_fetch_from_flash(ffl), .o_rdata(rdata), .o_busy(busy),
    .o_suspended(suspend_bit), .o_access_protected(aprot),
    .o_sector_protected(sprot), .o_array_addr(aaddr),
    .o_array_data(adata));
  fws_cpu_model i_cpu (.i_ref_clk(i_ref_clk), .i_rdata(rdata),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr_s), .o_rd(rd_s),
    .o_fetch_from_flash(ffl));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic complete_run;
    $display("mismatches %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic w(input logic [3:0] a, input logic [15:0] v);
    i_cpu.wr(a, v, 1'b0);
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    i_cpu.rd(a, d);
    `FWS_CHK(d, e)
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    `FWS_CHK(busy, 1'b0)
  endtask
  task automatic setprot(input logic [15:0] lo, input logic [15:0] v);
    w(4'h1, 16'h0100);
    w(4'h4, lo);
    w(4'h5, 16'h0008);
    w(4'h6, v);
    w(4'h1, 16'h8100);
    wait_idle();
  endtask
  initial begin
    i_resetn = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    #1;
    `FWS_CHK(sprot, 16'h0000)
    `FWS_CHK(aprot, 1'b0)
    rc(4'hC, 16'hFFFF);
    rc(4'hD, 16'h0000);
    w(4'h1, 16'h2000);
    rc(4'h1, 16'h2000);
    `FWS_CHK(busy, 1'b0)
    w(4'h4, 16'h5554);
    w(4'h5, 16'h0004);
    w(4'h6, 16'hAAAA);
    w(4'h7, 16'h5555);
    w(4'h1, 16'hA000);
    `FWS_CHK(busy, 1'b1)
    w(4'h4, 16'h1234);
    `FWS_CHK(aaddr, 32'h0004_5554)
    `FWS_CHK(adata, 64'h0000_0000_5555_AAAA)
    wait_idle();
    rc(4'h1, 16'h0000);
    rc(4'h4, 16'h5554);
    w(4'h1, 16'h1000);
    w(4'h4, 16'h555C);
    w(4'h5, 16'h0003);
    w(4'h6, 16'h55AA);
    w(4'h7, 16'h55AA);
    w(4'h8, 16'hAA55);
    w(4'h9, 16'hAA55);
    w(4'h1, 16'h9000);
    `FWS_CHK(aaddr, 32'h0003_5558)
    `FWS_CHK(adata, 64'hAA55_AA55_55AA_55AA)
    wait_idle();
    w(4'h1, 16'h2000);
    w(4'h1, 16'h0000);
    rc(4'h1, 16'h0000);
    // erase, suspend, nested double-word program, resume
    w(4'h1, 16'h0800);
    w(4'h2, 16'h0003);
    w(4'h1, 16'h8800);
    w(4'h1, 16'h4000);
    `FWS_CHK({busy, suspend_bit}, 2'b01)
    rc(4'h2, 16'h0003);
    w(4'h1, 16'h0000);
    w(4'h1, 16'h1000);
    w(4'h1, 16'h9000);
    i_cpu.rd(4'h1, d);
    `FWS_CHK(d & 16'h4800, 16'h0000)
    w(4'h1, 16'h4000);
    `FWS_CHK(busy, 1'b1)
    wait_idle();
    `FWS_CHK(suspend_bit, 1'b1)
    w(4'h1, 16'h0800);
    w(4'h1, 16'h8800);
    `FWS_CHK(busy, 1'b1)
    wait_idle();
    rc(4'h2, 16'h0000);
    rc(4'h3, 16'h0000);
    // suspended word program resumes with its own select
    w(4'h1, 16'h2000);
    w(4'h1, 16'hA000);
    w(4'h1, 16'h4000);
    `FWS_CHK({busy, suspend_bit}, 2'b01)
    w(4'h1, 16'hA000);
    `FWS_CHK({busy, suspend_bit}, 2'b10)
    wait_idle();
    rc(4'hA, 16'h0000);
    rc(4'h1, 16'h0000);
    // resume with another select aborts
    w(4'h1, 16'h2000);
    w(4'h1, 16'hA000);
    w(4'h1, 16'h4000);
    w(4'h1, 16'h9000);
    `FWS_CHK({busy, suspend_bit}, 2'b00)
    rc(4'hA, 16'h0001);
    rc(4'h1, 16'h0000);
    w(4'hA, 16'h0000);
    rc(4'hA, 16'h0000);
    setprot(16'hDFB4, 16'hFFF0);
    rc(4'hC, 16'hFFF0);
    `FWS_CHK(sprot, 16'h000F)
    w(4'hC, 16'hFFFF);
    rc(4'hC, 16'hFFF0);
    setprot(16'hDFB4, 16'hFFFF);
    rc(4'hC, 16'hFFF0);
    rc(4'hD, 16'hFFFF);
    `FWS_CHK(sprot, 16'h0000)
    setprot(16'hDFB4, 16'hFFFE);
    `FWS_CHK(sprot, 16'h0001)
    setprot(16'hDFB8, 16'hFFFC);
    `FWS_CHK(aprot, 1'b1)
    w(4'hB, 16'h0001);
    `FWS_CHK(aprot, 1'b1)
    i_cpu.wr(4'hB, 16'h0001, 1'b1);
    `FWS_CHK(aprot, 1'b0)
    setprot(16'hDFBC, 16'hFFFE);
    rc(4'hF, 16'hFFFE);
    w(4'hB, 16'h0000);
    `FWS_CHK(aprot, 1'b1)
    w(4'h4, 16'h0BAD);
    rc(4'h4, 16'hDFBC);
    complete_run();
  end
endmodule
`default_nettype wire
